// [inc/conv_pkg.sv]
`default_nettype none
package conv_pkg;
  // internal float is 1-8-23 binary32
  localparam int F_EXP_W = 8;
  localparam int F_MAN_W = 23;
  localparam int F_BIAS = 127;
  localparam logic [7:0] F_EXP_SPECIAL = 8'hff;
  localparam logic [7:0] F_EXP_TOP = 8'hfe;
  // fixed-point working format of the normalized paths
  localparam int FRAC_W = 48;
  localparam int ACC_W = 96;
  // small float fields
  localparam int SM_EXP_W = 5;
  localparam int SM_BIAS = 15;
  localparam int SM_EXP_SUB = -14;
  localparam logic [4:0] SM_EXP_SPECIAL = 5'h1f;
  localparam int HALF_MAN_W = 10;
  localparam int HALF_SIGN_BIT = 15;
  localparam int UF11_MAN_W = 6;
  localparam int UF10_MAN_W = 5;
  // 16.16 vertex attribute
  localparam int FIX_FRAC_W = 16;
  localparam int FIX_W = 32;
  // widest normalized integer
  localparam int MAX_BITS = 32;
  localparam int BW_W = 6;

  typedef enum logic [3:0] {
    OP_DEC_HALF = 4'h0,
    OP_DEC_UF11 = 4'h1,
    OP_DEC_UF10 = 4'h2,
    OP_DEC_FIX = 4'h3,
    OP_UNORM_TO_F = 4'h4,
    OP_SNORM_TO_F = 4'h5,
    OP_F_TO_UF11 = 4'h6,
    OP_F_TO_UF10 = 4'h7,
    OP_F_TO_UNORM = 4'h8,
    OP_F_TO_SNORM = 4'h9
  } op_e;
endpackage : conv_pkg
`default_nettype wire

// [rtl/numeric_format_converter.sv]
// Contract
// - float results accurate to one part in 1e5
// - float range at least 2^32, colours 2^10
// - times zero, times one, plus zero exact
// - inf and nan support optional
// - invalid float input never hangs datapath
// - half word: sign, 5-bit exponent, 10-bit mantissa
// - half decode: zero, subnormal, normal, inf/nan
// - half fields taken from unsigned word bits
// - subnormal and negative zero decode deterministically
// - 11-bit float: 5-bit exponent, 6-bit mantissa
// - 11-bit decode: zero, subnormal, normal, inf/nan
// - 11-bit encode rounds, clamps negatives, saturates 65024
// - encode: -inf to zero, +inf kept, nan positive
// - 10-bit float: 5-bit exponent, 5-bit mantissa
// - 10-bit encode rounds, clamps negatives, saturates 64512
// - fixed attributes are signed 16.16
// - division by zero never stalls datapath
// - unorm to float divides by 2^b-1
// - full-range snorm to float: (2c+1)/(2^b-1)
// - symmetric snorm: c/(2^(b-1)-1), clamped at -1
// - float to unorm: clamp, scale, b-bit cast
// - float to snorm: clamp, scale either way, cast
`default_nettype none
module numeric_format_converter (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [3:0] opSel,
  input wire logic [conv_pkg::BW_W-1:0] bitWidth,
  input wire logic snormSym,
  input wire logic roundToZero,
  input wire logic [31:0] inWord,
  output logic outValid,
  input wire logic outReady,
  output logic [31:0] outWord
);
  typedef struct packed {
    logic outValid;
    logic [31:0] outWord;
  } state_s;

  state_s st_r;
  state_s st_nxt;
  logic [1:0] rstSync_r;
  logic rstN;

  // reset asserts at once, releases two edges later
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      rstSync_r <= 2'h0;
    else
      rstSync_r <= {rstSync_r[0], 1'b1};
  end
  assign rstN = rstSync_r[1];

  // magnitude times 2^scale into binary32, truncating
  function automatic logic [31:0] toFloat(input logic neg, input logic [95:0] mag,
                                          input int scale);
    int msb;
    int e;
    logic [95:0] norm;
    msb = -1;
    for (int i = 0; i < conv_pkg::ACC_W; i++)
      if (mag[i])
        msb = i;
    norm = mag << (conv_pkg::ACC_W - 1 - msb);
    e = msb + scale + conv_pkg::F_BIAS;
    if (msb < 0 || e <= 0)
      return {neg, 31'h0};
    if (e >= 255)
      return {neg, conv_pkg::F_EXP_TOP, 23'h7fffff};
    return {neg, 8'(e), norm[94:72]};
  endfunction : toFloat

  // small float fields to binary32
  function automatic logic [31:0] decodeSmall(input logic neg, input logic [4:0] e,
                                              input logic [9:0] m, input int mw);
    logic [22:0] man;
    man = 23'(m) << (conv_pkg::F_MAN_W - mw);
    if (e == 5'h0)
      return toFloat(neg, 96'(m), conv_pkg::SM_EXP_SUB - mw);
    if (e == conv_pkg::SM_EXP_SPECIAL)
      return {neg, conv_pkg::F_EXP_SPECIAL, man};
    return {neg, 8'(int'(e) - conv_pkg::SM_BIAS + conv_pkg::F_BIAS), man};
  endfunction : decodeSmall

  // mag / (2^n - 1) as 48-bit fraction, 1.0 exact at the top code
  function automatic logic [95:0] divMersenne(input logic [95:0] mag, input int n);
    logic [95:0] acc;
    logic [95:0] lim;
    logic [95:0] sh;
    acc = 96'h0;
    lim = (96'h1 << n) - 96'h1;
    sh = mag << conv_pkg::FRAC_W;
    if (n == 0)
      return 96'h0;
    if (mag >= lim)
      return 96'h1 << conv_pkg::FRAC_W;
    for (int k = 1; k <= conv_pkg::FRAC_W; k++)
      if (n * k < conv_pkg::ACC_W)
        acc = acc + (sh >> (n * k));
    return acc;
  endfunction : divMersenne

  // |f| clamped to 1.0, as 48-bit fraction
  function automatic logic [95:0] absToFix(input logic [31:0] f);
    logic [7:0] e;
    logic [95:0] sig;
    e = f[30:23];
    sig = {72'h0, 1'b1, f[22:0]};
    if (e == 8'h0)
      return 96'h0;
    if (e >= 8'(conv_pkg::F_BIAS))
      return 96'h1 << conv_pkg::FRAC_W;
    if (int'(e) >= conv_pkg::F_BIAS + conv_pkg::F_MAN_W - conv_pkg::FRAC_W)
      return sig << (int'(e) - (conv_pkg::F_BIAS + conv_pkg::F_MAN_W - conv_pkg::FRAC_W));
    return sig >> ((conv_pkg::F_BIAS + conv_pkg::F_MAN_W - conv_pkg::FRAC_W) - int'(e));
  endfunction : absToFix

  // binary32 to unsigned small float of mw mantissa bits
  function automatic logic [10:0] encodeSmall(input logic [31:0] f, input int mw,
                                              input logic rtz);
    logic [7:0] e;
    logic [23:0] sig;
    logic [11:0] word;
    logic [11:0] infWord;
    logic guard;
    int ue;
    int sh;
    e = f[30:23];
    sig = {1'b1, f[22:0]};
    infWord = 12'(conv_pkg::SM_EXP_SPECIAL) << mw;
    guard = 1'b0;
    ue = int'(e) - conv_pkg::F_BIAS;
    if (e == conv_pkg::F_EXP_SPECIAL && f[22:0] != 23'h0)
      return 11'(infWord | (12'h1 << (mw - 1)));
    if (f[31] || e == 8'h0)
      return 11'h0;
    if (e == conv_pkg::F_EXP_SPECIAL)
      return 11'(infWord);
    if (ue > conv_pkg::SM_BIAS)
      return 11'(infWord - 12'h1);
    if (ue >= conv_pkg::SM_EXP_SUB)
    begin
      word = (12'(ue + conv_pkg::SM_BIAS) << mw) | 12'(f[22:0] >> (conv_pkg::F_MAN_W - mw));
      guard = f[conv_pkg::F_MAN_W - 1 - mw];
    end
    else
    begin
      sh = (conv_pkg::F_MAN_W - mw) + (conv_pkg::SM_EXP_SUB - ue);
      word = (sh > 24) ? 12'h0 : 12'(sig >> sh);
      guard = (sh > 24) ? 1'b0 : sig[sh - 1];
    end
    if (!rtz && guard)
      word = word + 12'h1;
    if (word >= infWord)
      word = infWord - 12'h1;
    return 11'(word);
  endfunction : encodeSmall

  logic [31:0] result;
  int bw;
  logic [95:0] bMask;
  logic cNeg;
  logic [95:0] cMag;
  logic [95:0] fx;
  logic [95:0] t;
  logic [95:0] v;
  logic [95:0] q;
  int n;
  logic halfSign;
  logic [4:0] halfExp;
  logic [9:0] halfMan;
  logic [4:0] uf11Exp;
  logic [5:0] uf11Man;
  logic [4:0] uf10Exp;
  logic [4:0] uf10Man;

  // fields by the unsigned word view of each small format
  assign halfSign = inWord[conv_pkg::HALF_SIGN_BIT];
  assign halfExp = inWord[14:10];
  assign halfMan = inWord[9:0];
  assign uf11Exp = inWord[10:6];
  assign uf11Man = inWord[5:0];
  assign uf10Exp = inWord[9:5];
  assign uf10Man = inWord[4:0];

  always_comb
  begin
    result = 32'h0;
    bw = int'(bitWidth);
    if (bw > conv_pkg::MAX_BITS)
      bw = conv_pkg::MAX_BITS;
    bMask = (96'h1 << bw) - 96'h1;
    cNeg = (bw > 0) ? inWord[bw - 1] : 1'b0;
    cMag = 96'(inWord) & bMask;
    fx = absToFix(inWord);
    t = 96'h0;
    v = 96'h0;
    q = 96'h0;
    n = (snormSym) ? bw - 1 : bw;
    unique case (opSel)
      // decoders: small floats and 16.16 to binary32
      conv_pkg::OP_DEC_HALF:
      begin
        result = decodeSmall(halfSign, halfExp, halfMan,
                             conv_pkg::HALF_MAN_W);
      end
      conv_pkg::OP_DEC_UF11:
      begin
        result = decodeSmall(1'b0, uf11Exp, {4'h0, uf11Man},
                             conv_pkg::UF11_MAN_W);
      end
      conv_pkg::OP_DEC_UF10:
      begin
        result = decodeSmall(1'b0, uf10Exp, {5'h0, uf10Man},
                             conv_pkg::UF10_MAN_W);
      end
      conv_pkg::OP_DEC_FIX:
      begin
        t = inWord[31] ? 96'h0 - 96'($signed(inWord)) : 96'(inWord);
        result = toFloat(inWord[31], t, -conv_pkg::FIX_FRAC_W);
      end
      // normalized integers to binary32
      conv_pkg::OP_UNORM_TO_F:
      begin
        result = toFloat(1'b0, divMersenne(cMag, bw), -conv_pkg::FRAC_W);
      end
      conv_pkg::OP_SNORM_TO_F:
      begin
        t = cNeg ? (bMask + 96'h1) - cMag : cMag;
        if (!snormSym)
          t = cNeg ? (t << 1) - 96'h1 : (t << 1) + 96'h1;
        result = toFloat(cNeg, divMersenne(t, n), -conv_pkg::FRAC_W);
      end
      // encoders: binary32 to unsigned small floats
      conv_pkg::OP_F_TO_UF11:
      begin
        result = {21'h0, encodeSmall(inWord, conv_pkg::UF11_MAN_W, roundToZero)};
      end
      conv_pkg::OP_F_TO_UF10:
      begin
        result = {21'h0, encodeSmall(inWord, conv_pkg::UF10_MAN_W, roundToZero)};
      end
      // binary32 to normalized integers, cast truncates
      conv_pkg::OP_F_TO_UNORM:
      begin
        t = inWord[31] ? 96'h0 : (fx << bw) - fx;
        result = 32'((t >> conv_pkg::FRAC_W) & bMask);
      end
      conv_pkg::OP_F_TO_SNORM:
      begin
        t = (fx << n) - fx;
        v = inWord[31] ? 96'h0 - t : t;
        if (!snormSym)
          v = v - (96'h1 << conv_pkg::FRAC_W);
        q = v[95] ? 96'h0 - v : v;
        if (!snormSym)
          q = q >> 1;
        q = q >> conv_pkg::FRAC_W;
        q = v[95] ? 96'h0 - q : q;
        result = 32'(q & bMask);
      end
      // spare codes answer zero and never stall
      default:
      begin
        result = 32'h0;
      end
    endcase
  end

  // accept whenever the held result leaves at this edge
  assign inReady = !st_r.outValid || outReady;

  always_comb
  begin
    st_nxt = st_r;
    if (st_r.outValid && outReady)
      st_nxt.outValid = 1'b0;
    // a request taken with the drop keeps outValid high
    if (inValid && inReady)
    begin
      st_nxt.outValid = 1'b1;
      st_nxt.outWord = result;
    end
  end

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign outValid = st_r.outValid;
  assign outWord = st_r.outWord;
endmodule : numeric_format_converter
`default_nettype wire

// [tb/conv_checker_assertions.sv]
`default_nettype none
module conv_checker (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic inValid,
  input wire logic inReady,
  input wire logic [3:0] opSel,
  input wire logic [conv_pkg::BW_W-1:0] bitWidth,
  input wire logic snormSym,
  input wire logic roundToZero,
  input wire logic [31:0] inWord,
  input wire logic outValid,
  input wire logic outReady,
  input wire logic [31:0] outWord
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire logic tk = inValid && inReady;
  ready_rule_a: assert property (inReady == (!outValid || outReady))
    else $error("ready not derived from output stage");
  answer_next_a: assert property (tk |=> outValid)
    else $error("no result one cycle after request");
  result_holds_a: assert property (
    outValid && !outReady |=> outValid && $stable(outWord))
    else $error("result changed while stalled");
  result_drops_a: assert property (
    outValid && outReady && !inValid |=> !outValid)
    else $error("result stayed after it was taken");
  half_zero_a: assert property (
    tk && opSel == conv_pkg::OP_DEC_HALF && inWord[14:0] == 15'h0
    |=> outWord == {$past(inWord[15]), 31'h0})
    else $error("signed zero decode wrong");
  half_norm_a: assert property (
    tk && opSel == conv_pkg::OP_DEC_HALF && inWord[14:10] != 5'h0 && inWord[14:10] != 5'h1f
    |=> outWord[22:13] == $past(inWord[9:0]) && outWord[31] == $past(inWord[15])
    && outWord[30:23] == $past(inWord[14:10]) + 8'h70)
    else $error("normal half decode wrong");
  neg_zero_a: assert property (
    tk && opSel == conv_pkg::OP_F_TO_UF11 && inWord[31]
    && (inWord[30:23] != 8'hff || inWord[22:0] == 23'h0) |=> outWord == 32'h0)
    else $error("negative value not encoded as zero");
  nan_pos_a: assert property (
    tk && opSel == conv_pkg::OP_F_TO_UF11 && inWord[30:23] == 8'hff
    && inWord[22:0] != 23'h0 |=> outWord == 32'h7e0)
    else $error("nan not encoded as positive nan");
  unorm_width_a: assert property (
    tk && opSel == conv_pkg::OP_F_TO_UNORM && bitWidth < 6'h20
    |=> (outWord >> $past(bitWidth)) == 32'h0)
    else $error("unorm result wider than b bits");
endmodule : conv_checker
`default_nettype wire

// [tb/downstream_model.sv]
`default_nettype none
module downstream_model (
  input wire logic ref_clk,
  input wire logic stall,
  output logic outReady
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh = 8'ha5;
  // random back pressure only while stall mode is on
  initial
  begin
    outReady = 1'b1;
    forever
    begin
      @(posedge ref_clk);
      sh <= {sh[6:0], sh[7] ^ sh[5] ^ sh[4] ^ sh[3]};
      outReady <= !stall || sh[0];
    end
  end
endmodule : downstream_model
`default_nettype wire

// [tb/numeric_format_converter_tb.sv]
`default_nettype none
module numeric_format_converter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, reset_n = 1'b0, inValid = 1'b0, snormSym = 1'b0;
  logic roundToZero = 1'b0, stall = 1'b0, inReady, outValid, outReady, k;
  logic [3:0] opSel = 4'h0;
  logic [conv_pkg::BW_W-1:0] bitWidth = 6'h00;
  logic [31:0] inWord = 32'h0, outWord, r = 32'hcb39bef9;
  logic [4:0] e;
  logic [31:0] q[$];
  int nMismatch = 0, numChecks = 0;
  // op nibble, rtz, sym, width, operand, expected
  localparam logic [75:0] CV [32] = '{
    76'h00000003c003f800000, 76'h0000000800080000000, 76'h0000000000133800000,
    76'h00000007c007f800000, 76'h100000007c07f800000, 76'h1000000000135800000,
    76'h2000000000136000000, 76'h300000100003f800000, 76'h300ffff0000bf800000,
    76'h401000000013f800000, 76'h4080000000000000000, 76'h508ffffff80bf800000,
    76'h5080000007f3f800000, 76'h548ffffff80bf800000, 76'h5480000007f3f800000,
    76'h6003f800000000003c0, 76'h6003f810000000003c1, 76'h6803f810000000003c0,
    76'h6007f7fffff000007bf, 76'h600bf80000000000000, 76'h600ff80000000000000,
    76'h6007f800000000007c0, 76'h600ffc00000000007e0, 76'h7003f800000000001e0,
    76'h7007f7fffff000003df, 76'h7007fc00000000003f0, 76'h8083f800000000000ff,
    76'h80840000000000000ff, 76'h8083f0000000000007f, 76'h908bf80000000000080,
    76'h948bf80000000000081, 76'hf003f80000000000000};
  initial forever #2.5 ref_clk = ~ref_clk;
  numeric_format_converter numeric_format_converter_inst (.ref_clk(ref_clk),
    .reset_n(reset_n), .inValid(inValid), .inReady(inReady), .opSel(opSel),
    .bitWidth(bitWidth), .snormSym(snormSym), .roundToZero(roundToZero),
    .inWord(inWord), .outValid(outValid), .outReady(outReady), .outWord(outWord));
  downstream_model downstream_model_inst (.ref_clk(ref_clk), .stall(stall),
    .outReady(outReady));
  function logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nx
  function logic [31:0] fl(input logic s, input logic [4:0] x, input logic [22:0] m);
    return {s, 8'(x) + 8'h70, m};
  endfunction : fl
  task chk(input logic [31:0] s, input logic [31:0] w);
    numChecks++;
    if (s !== w)
    begin
      nMismatch++;
      $display("BAD t=%0t seen=%h want=%h", $time, s, w);
    end
  endtask : chk
  task t(input logic [11:0] c, input logic [31:0] w, input logic [31:0] x);
    inValid <= 1'b1;
    {opSel, roundToZero, snormSym, bitWidth} <= c;
    inWord <= w;
    q.push_back(x);
    do
    begin
      @(negedge ref_clk);
      k = inReady;
      @(posedge ref_clk);
    end while (k !== 1'b1);
  endtask : t
  task tv(input int i);
    t(CV[i][75:64], CV[i][63:32], CV[i][31:0]);
  endtask : tv
  task stopTest;
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stopTest
  always @(negedge ref_clk)
    if (outValid === 1'b1 && outReady === 1'b1)
      chk(outWord, q.pop_front());
  initial
  begin
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < 7; i++)
      tv(i);
    for (int i = 7; i < 11; i++)
      tv(i);
    for (int i = 11; i < 15; i++)
      tv(i);
    for (int i = 15; i < 26; i++)
      tv(i);
    for (int i = 26; i < 32; i++)
      tv(i);
    $display("corner tests done");
    stall <= 1'b1;
    for (int i = 0; i < 90; i++)
    begin
      r = nx(r);
      e = 5'(r[20:16] % 5'h1e) + 5'h01;
      case (i % 3)
        0: t(12'h000, {16'h0, r[15], e, r[9:0]}, fl(r[15], e, {r[9:0], 13'h0}));
        1: t(12'h100, {21'h0, e, r[5:0]}, fl(1'b0, e, {r[5:0], 17'h0}));
        default: t(12'h200, {22'h0, e, r[4:0]}, fl(1'b0, e, {r[4:0], 18'h0}));
      endcase
    end
    inValid <= 1'b0;
    repeat (40) @(posedge ref_clk);
    chk(32'(q.size()), 32'h0);
    $display("random tests done");
    stopTest();
  end
  initial
  begin
    #100000;
    nMismatch++;
    stopTest();
  end
endmodule : numeric_format_converter_tb
bind numeric_format_converter conv_checker conv_checker_inst (.ref_clk(ref_clk),
  .reset_n(reset_n), .inValid(inValid), .inReady(inReady), .opSel(opSel),
  .bitWidth(bitWidth), .snormSym(snormSym), .roundToZero(roundToZero),
  .inWord(inWord), .outValid(outValid), .outReady(outReady), .outWord(outWord));
`default_nettype wire
